// [hdl/data_buffer_map.vh]
// Purpose: constants for the host/memory/PCI data buffer
// Assumes: included by bare name
// Notes:   definitions only
`ifndef DATA_BUFFER_MAP_VH
`define DATA_BUFFER_MAP_VH
`define SEL_FLOAT      2'h0
`define SEL_ONES       2'h1
`define SEL_PCI        2'h2
`define SEL_MEM        2'h3
`define PCI_Q_LEVELS   4
`define PCI_Q_DWS      4
`define MEM_BUF_QWS    4
`define PTR_RESET      4'h0
`define CPU_CLK_MHZ_X10 667
`define PCI_CLK_MHZ_X10 333
`endif

// [hdl/local_data_buffer.v]
// Purpose: data buffer joining host, memory and PCI data buses
// Assumes: all strobes synchronous to ref_clk from the controller
// Notes:   pins are split into in/out/oe; bus levels resolved outside
`timescale 1ns/100ps
`include "data_buffer_map.vh"
module local_data_buffer #(
	parameter PCI_LEVELS = `PCI_Q_LEVELS,
	parameter MEM_QWS    = `MEM_BUF_QWS
) (
	input  wire        ref_clk,
	input  wire        nrst,
	input  wire        cpu_reset,
	input  wire [1:0]  host_bus_source_select,
	input  wire        pci_queue_push,
	input  wire        pci_queue_pop,
	input  wire        mem_queue_push,
	input  wire        mem_queue_pop,
	input  wire        pci_out_latch,
	input  wire        ad_latch_n,
	input  wire        mem_latch_en,
	input  wire        ad_out_en,
	input  wire        mem_write_n,
	input  wire        high_dword_flag,
	input  wire        host_ready,
	input  wire [63:0] host_data_bus_in,
	output reg  [63:0] host_data_bus_out,
	output wire        host_data_bus_oe,
	input  wire [63:0] memory_data_bus_in,
	output reg  [63:0] memory_data_bus_out,
	output wire        memory_data_bus_oe,
	input  wire [7:0]  mem_parity_in,
	output reg  [7:0]  mem_parity_out,
	input  wire [31:0] pci_ad_in,
	output reg  [31:0] pci_ad_out,
	output wire        pci_ad_oe,
	output reg         parity_error_n,
	output wire        pci_queue_full,
	output wire        pci_queue_empty,
	output wire        host_stall
);
	localparam PQ_DEPTH = PCI_LEVELS * `PCI_Q_DWS;
	localparam PQ_AW    = 4;
	localparam MQ_AW    = 2;

	reg [31:0]      pq_mem [0:PQ_DEPTH-1];
	reg [PQ_AW:0]   pq_wp_q;
	reg [PQ_AW:0]   pq_rp_q;
	reg [63:0]      mq_mem [0:MEM_QWS-1];
	reg [MQ_AW-1:0] mq_wp_q;
	reg [MQ_AW-1:0] mq_rp_q;
	reg [MQ_AW:0]   mq_cnt_q;
	reg [63:0]      p2m_q;
	reg [63:0]      m2c_q;
	reg [63:0]      m2p_q;
	reg             push_d1_q;
	reg             pop_d1_q;
	reg             ad_le_d1_q;
	reg             mem_le_d1_q;
	reg             m2c_chk_q;
	wire            push_rise;
	wire            pop_rise;
	wire            ad_le_act;
	wire [63:0]     ret_data;
	wire            ret_valid;
	wire            ret_ready;
	wire            buf_valid;
	wire [63:0]     buf_data;
	integer         i;

	function [7:0] gen_par;
		input [63:0] d;
		integer k;
		begin
			for (k = 0; k < 8; k = k + 1)
				gen_par[k] = ~^d[8*k +: 8];
		end
	endfunction

	// PCI queue push and pop strobes are edge events; detect once on the shared clock
	assign push_rise = pci_queue_push & ~push_d1_q;
	assign pop_rise  = pci_queue_pop & ~pop_d1_q;
	assign ad_le_act = ~ad_latch_n;

	// full and empty let the controller throttle writes and reads
	assign pci_queue_full  = (pq_wp_q[PQ_AW-1:0] == pq_rp_q[PQ_AW-1:0])
	                         & (pq_wp_q[PQ_AW] != pq_rp_q[PQ_AW]);
	assign pci_queue_empty = (pq_wp_q == pq_rp_q);

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			push_d1_q   <= 1'b0;
			pop_d1_q    <= 1'b0;
			ad_le_d1_q  <= 1'b0;
			mem_le_d1_q <= 1'b0;
		end else begin
			push_d1_q   <= pci_queue_push;
			pop_d1_q    <= pci_queue_pop;
			ad_le_d1_q  <= ad_le_act;
			mem_le_d1_q <= mem_latch_en;
		end
	end

	// host-to-PCI queue, doubleword wide, high half chosen by flag
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pq_wp_q <= {(PQ_AW+1){1'b0}};
			pq_rp_q <= {(PQ_AW+1){1'b0}};
		end else if (cpu_reset) begin
			pq_wp_q <= {(PQ_AW+1){1'b0}};
			pq_rp_q <= {(PQ_AW+1){1'b0}};
		end else begin
			if (push_rise && !pci_queue_full)
				pq_wp_q <= pq_wp_q + 1'b1;
			if (pop_rise && !pci_queue_empty)
				pq_rp_q <= pq_rp_q + 1'b1;
		end
	end

	always @(posedge ref_clk) begin
		if (push_rise && !pci_queue_full)
			pq_mem[pq_wp_q[PQ_AW-1:0]] <= high_dword_flag ?
				host_data_bus_in[63:32] : host_data_bus_in[31:0];
	end

	// host-to-memory buffer; pointers wrap over one level of quadwords
	// a fill count tells a full buffer from an empty one after the wrap
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mq_wp_q  <= {MQ_AW{1'b0}};
			mq_rp_q  <= {MQ_AW{1'b0}};
			mq_cnt_q <= {(MQ_AW+1){1'b0}};
		end else if (cpu_reset) begin
			mq_wp_q  <= {MQ_AW{1'b0}};
			mq_rp_q  <= {MQ_AW{1'b0}};
			mq_cnt_q <= {(MQ_AW+1){1'b0}};
		end else begin
			if (mem_queue_push && !mem_queue_pop
			    && mq_cnt_q != MEM_QWS)
				mq_cnt_q <= mq_cnt_q + 1'b1;
			else if (mem_queue_pop && !mem_queue_push
			         && mq_cnt_q != {(MQ_AW+1){1'b0}})
				mq_cnt_q <= mq_cnt_q - 1'b1;
			if (mem_queue_push)
				mq_wp_q <= mq_wp_q + 1'b1;
			if (mem_queue_pop)
				mq_rp_q <= mq_rp_q + 1'b1;
		end
	end

	always @(posedge ref_clk) begin
		if (mem_queue_push)
			mq_mem[mq_wp_q] <= host_data_bus_in;
	end

	// PCI- and CPU-side latches: PCI assembly and memory read buffers
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			p2m_q     <= 64'h0;
			m2c_q     <= 64'h0;
			m2p_q     <= 64'h0;
			m2c_chk_q <= 1'b0;
		end else begin
			m2c_chk_q <= 1'b0;
			if (ad_le_act) begin
				if (high_dword_flag)
					p2m_q[63:32] <= pci_ad_in;
				else
					p2m_q[31:0] <= pci_ad_in;
			end
			// read buffer closes on falling latch enable
			if (mem_le_d1_q && !mem_latch_en) begin
				m2c_q     <= memory_data_bus_in;
				m2c_chk_q <= 1'b1;
			end
			if (ad_le_act && !ad_le_d1_q)
				m2p_q <= (host_bus_source_select == `SEL_FLOAT) ?
					host_data_bus_in : memory_data_bus_in;
		end
	end

	// parity check only on CPU read path; PCI path ignores it
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			parity_error_n <= 1'b1;
		else if (cpu_reset)
			parity_error_n <= 1'b1;
		else if (m2c_chk_q)
			parity_error_n <= (gen_par(m2c_q) == mem_parity_in);
	end

	// memory write data: popped host data, or posted PCI data
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			memory_data_bus_out <= 64'h0;
			mem_parity_out      <= 8'h0;
		end else if (!mem_write_n) begin
			if (mq_cnt_q != {(MQ_AW+1){1'b0}} || mem_queue_pop) begin
				memory_data_bus_out <= mq_mem[mq_rp_q];
				mem_parity_out      <= gen_par(mq_mem[mq_rp_q]);
			end else begin
				memory_data_bus_out <= p2m_q;
				mem_parity_out      <= gen_par(p2m_q);
			end
		end
	end
	assign memory_data_bus_oe = ~mem_write_n;

	// PCI output prelatch: queue head, or memory read buffer half
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			pci_ad_out <= 32'h0;
		else if (pci_out_latch) begin
			if (!pci_queue_empty)
				pci_ad_out <= pq_mem[pq_rp_q[PQ_AW-1:0]];
			else if (high_dword_flag)
				pci_ad_out <= m2p_q[63:32];
			else
				pci_ad_out <= m2p_q[31:0];
		end
	end
	assign pci_ad_oe = ad_out_en;

	// host return data passes a two-entry buffer so a stall loses nothing
	assign ret_data  = (host_bus_source_select == `SEL_MEM) ? m2c_q :
	                   (host_bus_source_select == `SEL_PCI) ? p2m_q :
	                   {64{1'b1}};
	assign ret_valid = (host_bus_source_select != `SEL_FLOAT);

	skid_buffer #(
		.W(64)
	) u_ret (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.in_valid  (ret_valid),
		.in_ready  (ret_ready),
		.in_data   (ret_data),
		.out_valid (buf_valid),
		.out_ready (host_ready),
		.out_data  (buf_data)
	);
	assign host_stall = ret_valid & ~ret_ready;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			host_data_bus_out <= 64'h0;
		else if (buf_valid && host_ready)
			host_data_bus_out <= buf_data;
	end
	// float when select is 00 and nothing is left to hand over
	assign host_data_bus_oe = ret_valid | buf_valid;
endmodule // local_data_buffer

// [hdl/skid_buffer.v]
// Purpose: two-entry valid/ready buffer on the host read return path
// Assumes: single clock, asynchronous active-low reset
// Notes:   full throughput, no word lost under stall
`timescale 1ns/100ps
module skid_buffer #(
	parameter W = 64
) (
	input  wire         ref_clk,
	input  wire         nrst,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem_q [0:1];
	reg         wp_q;
	reg         rp_q;
	reg [1:0]   cnt_q;
	wire        push;
	wire        pop;

	assign in_ready  = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data  = mem_q[rp_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wp_q     <= 1'b0;
			rp_q     <= 1'b0;
			cnt_q    <= 2'h0;
			mem_q[0] <= {W{1'b0}};
			mem_q[1] <= {W{1'b0}};
		end else begin
			if (push) begin
				mem_q[wp_q] <= in_data;
				wp_q        <= ~wp_q;
			end
			if (pop)
				rp_q <= ~rp_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // skid_buffer

// [testbench/controller_model.sv]
// Purpose: model of the controller that strobes the data buffer
// Assumes: every strobe changes 1 ns after ref_clk rises
// Notes:   host_drive is the host side's level on the data bus
`timescale 1ns/100ps
module controller_model (
	input  wire        ref_clk,
	input  wire        pci_queue_full,
	output reg         cpu_reset = 1'b0,
	output reg  [1:0]  host_bus_source_select = 2'h0,
	output reg         pci_queue_push = 1'b0,
	output reg         pci_queue_pop = 1'b0,
	output reg         pci_out_latch = 1'b0,
	output reg         high_dword_flag = 1'b0,
	output reg  [63:0] host_drive = 64'h0
);
	task step;
		@(posedge ref_clk) #1;
	endtask
	// other half inverted so a wrong half shows
	task push(input [31:0] dw, input hi);
		while (pci_queue_full) step;
		high_dword_flag = hi;
		host_drive = hi ? {dw, ~dw} : {~dw, dw};
		pci_queue_push = 1'b1;
		step;
		pci_queue_push = 1'b0;
		host_drive = ~host_drive;
		step;
	endtask
	// prelatch the head, then step past it
	task pull;
		pci_out_latch = 1'b1;
		step;
		pci_out_latch = 1'b0;
		pci_queue_pop = 1'b1;
		step;
		pci_queue_pop = 1'b0;
		step;
	endtask
endmodule // controller_model

// [testbench/local_data_buffer_bench.sv]
// Purpose: self-checking bench for local_data_buffer
// Assumes: controller_model launches the PCI queue, select and reset strobes; the bench drives the memory strobes
// Notes:   ad_latch_n and pci_ad_in held idle
`timescale 1ns/100ps
`include "data_buffer_map.vh"
module local_data_buffer_bench;
	reg         ref_clk = 1'b0;
	reg         nrst = 1'b0;
	reg         mem_queue_push = 1'b0, mem_queue_pop = 1'b0;
	reg         mem_latch_en = 1'b0, ad_out_en = 1'b0;
	reg         mem_write_n = 1'b1, host_ready = 1'b0;
	reg  [63:0] mem_drive = 64'h0;
	reg  [7:0]  mem_parity_in = 8'h0;
	wire [63:0] host_drive, host_data_bus_out, memory_data_bus_out;
	wire [31:0] pci_ad_out;
	wire [7:0]  mem_parity_out;
	wire [1:0]  host_bus_source_select;
	wire        cpu_reset, pci_queue_push, pci_queue_pop, pci_out_latch;
	wire        high_dword_flag, host_data_bus_oe, memory_data_bus_oe;
	wire        pci_ad_oe, parity_error_n, pci_queue_full, pci_queue_empty;
	integer     bad_count = 0, tests_run = 0, i;
	wire [63:0] host_data_bus_in =
		host_data_bus_oe ? host_data_bus_out : host_drive;
	wire [63:0] memory_data_bus_in =
		memory_data_bus_oe ? memory_data_bus_out : mem_drive;
	always #12.5 ref_clk = ~ref_clk;
	function [63:0] qw(input integer k);
		qw = 64'h0123456789ABCDEF * (k + 3);
	endfunction
	function [7:0] par(input [63:0] d);
		integer k;
		for (k = 0; k < 8; k = k + 1)
			par[k] = ~^d[8*k +: 8];
	endfunction
	task check(input [63:0] seen, want);
		tests_run = tests_run + 1;
		if (seen !== want) begin
			bad_count = bad_count + 1;
			$display("wrong value at %0t: seen %h want %h", $time, seen, want);
		end
	endtask
	task end_sim;
		if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	local_data_buffer DUT (
		.ref_clk(ref_clk), .nrst(nrst), .cpu_reset(cpu_reset),
		.host_bus_source_select(host_bus_source_select),
		.pci_queue_push(pci_queue_push), .pci_queue_pop(pci_queue_pop),
		.mem_queue_push(mem_queue_push), .mem_queue_pop(mem_queue_pop),
		.pci_out_latch(pci_out_latch), .ad_latch_n(1'b1),
		.mem_latch_en(mem_latch_en), .ad_out_en(ad_out_en),
		.mem_write_n(mem_write_n), .high_dword_flag(high_dword_flag),
		.host_ready(host_ready), .host_data_bus_in(host_data_bus_in),
		.host_data_bus_out(host_data_bus_out),
		.host_data_bus_oe(host_data_bus_oe),
		.memory_data_bus_in(memory_data_bus_in),
		.memory_data_bus_out(memory_data_bus_out),
		.memory_data_bus_oe(memory_data_bus_oe),
		.mem_parity_in(mem_parity_in), .mem_parity_out(mem_parity_out),
		.pci_ad_in(32'h0), .pci_ad_out(pci_ad_out), .pci_ad_oe(pci_ad_oe),
		.parity_error_n(parity_error_n), .pci_queue_full(pci_queue_full),
		.pci_queue_empty(pci_queue_empty), .host_stall());
	controller_model ctl (
		.ref_clk(ref_clk), .pci_queue_full(pci_queue_full),
		.cpu_reset(cpu_reset), .host_drive(host_drive),
		.host_bus_source_select(host_bus_source_select),
		.pci_queue_push(pci_queue_push), .pci_queue_pop(pci_queue_pop),
		.pci_out_latch(pci_out_latch), .high_dword_flag(high_dword_flag));
	task t_queue;
		for (i = 0; i < `PCI_Q_LEVELS * `PCI_Q_DWS; i = i + 1) begin
			check(pci_queue_full, 1'b0);
			ctl.push(32'hA500 + i, i[0]);
		end
		check(pci_queue_full, 1'b1);
		ad_out_en = 1'b1;
		for (i = 0; i < `PCI_Q_LEVELS * `PCI_Q_DWS; i = i + 1) begin
			ctl.pull;
			check(pci_ad_out, 32'hA500 + i);
		end
		check({pci_queue_empty, pci_ad_oe}, 2'h3);
		ad_out_en = 1'b0;
		ctl.push(32'h1, 1'b0);
		ctl.cpu_reset = 1'b1;
		ctl.step;
		ctl.cpu_reset = 1'b0;
		ctl.step;
		check(pci_queue_empty, 1'b1);
	endtask
	task t_mem;
		mem_queue_push = 1'b1;
		for (i = 0; i < `MEM_BUF_QWS; i = i + 1) begin
			ctl.host_drive = qw(i);
			ctl.step;
		end
		mem_queue_push = 1'b0;
		mem_write_n = 1'b0;
		for (i = 0; i < `MEM_BUF_QWS; i = i + 1) begin
			repeat (2) ctl.step;
			check(memory_data_bus_out, qw(i));
			check(mem_parity_out, par(qw(i)));
			check(memory_data_bus_oe, 1'b1);
			mem_queue_pop = 1'b1;
			ctl.step;
			mem_queue_pop = 1'b0;
		end
		mem_write_n = 1'b1;
	endtask
	task t_read;
		for (i = 0; i < 2; i = i + 1) begin
			mem_drive = qw(i + 8);
			mem_parity_in = par(mem_drive) ^ i[7:0];
			mem_latch_en = 1'b1;
			ctl.step;
			mem_latch_en = 1'b0;
			repeat (3) ctl.step;
			check(parity_error_n, i == 0);
		end
		// memory has let go; only the latch still holds the word
		mem_drive = ~mem_drive;
		ctl.host_bus_source_select = 2'h3;
		repeat (3) ctl.step;
		host_ready = 1'b1;
		repeat (2) ctl.step;
		check(host_data_bus_out, qw(9));
		ctl.host_bus_source_select = 2'h1;
		repeat (3) ctl.step;
		check(host_data_bus_out, {64{1'b1}});
		ctl.host_bus_source_select = 2'h0;
		ctl.step;
		check(host_data_bus_oe, 1'b0);
		repeat (3) ctl.step;
		check(host_data_bus_oe, 1'b0);
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		#1 nrst = 1'b1;
		check({pci_queue_empty, parity_error_n}, 2'h3);
		t_queue;
		t_mem;
		t_read;
		end_sim;
	end
	// about six and a half times the expected run
	initial begin
		#20000;
		bad_count = bad_count + 1;
		end_sim;
	end
endmodule // local_data_buffer_bench

// [testbench/local_data_buffer_monitor.sv]
// Purpose: port assertions for local_data_buffer
// Assumes: single clock, nrst active low
// Notes:   bound after the module
`timescale 1ns/100ps
module local_data_buffer_monitor (
	input wire        ref_clk,
	input wire        nrst,
	input wire        cpu_reset,
	input wire [1:0]  host_bus_source_select,
	input wire        pci_queue_push,
	input wire        pci_queue_pop,
	input wire        host_ready,
	input wire [63:0] host_data_bus_out,
	input wire        host_data_bus_oe,
	input wire        pci_queue_full,
	input wire        pci_queue_empty
);
	wire [1:0] sel   = host_bus_source_select;
	wire       full  = pci_queue_full;
	wire       empty = pci_queue_empty;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// return buffer may still hold two older words; three drains flush it
	AST_ONES: assert property (
		(sel == 2'h1 && host_ready) [*3] |=> &host_data_bus_out)
		else $error("ones not driven");
	AST_FLOAT: assert property (
		(sel == 2'h0 && host_ready) [*3] |-> !host_data_bus_oe)
		else $error("floated bus driven");
	AST_DRIVE: assert property (sel != 2'h0 |-> host_data_bus_oe)
		else $error("bus not driven");
	AST_PUSH: assert property (
		$rose(pci_queue_push) && !cpu_reset |=> !empty)
		else $error("push lost");
	AST_CLEAR: assert property (cpu_reset |=> empty && !full)
		else $error("clear left data");
	AST_KEEP: assert property (
		!empty && !cpu_reset && !$rose(pci_queue_pop) |=> !empty)
		else $error("entry vanished");
	AST_STAY_FULL: assert property (
		full && !cpu_reset && !$rose(pci_queue_pop) |=> full)
		else $error("full dropped");
	AST_FULL_NE: assert property (full |-> !empty)
		else $error("full and empty");
endmodule // local_data_buffer_monitor
bind local_data_buffer local_data_buffer_monitor mon (
	.ref_clk(ref_clk), .nrst(nrst), .cpu_reset(cpu_reset),
	.host_bus_source_select(host_bus_source_select),
	.pci_queue_push(pci_queue_push), .pci_queue_pop(pci_queue_pop),
	.host_ready(host_ready),
	.host_data_bus_out(host_data_bus_out),
	.host_data_bus_oe(host_data_bus_oe),
	.pci_queue_full(pci_queue_full), .pci_queue_empty(pci_queue_empty));
